// ==== inc/irq_pkg.sv ====
// Constants, register map and types of the external interrupt and pending logic
package irq_pkg;

    // ************************************************************
    // Register indices; byte address is four times the index
    // ************************************************************
    localparam logic [7:0] IDX_EXT_FLAGS   = 8'h3a;
    localparam logic [7:0] IDX_EXT_MASK    = 8'h3b;
    localparam logic [7:0] IDX_MCU_CTRL    = 8'h35;
    localparam logic [7:0] IDX_STATUS_REG  = 8'h3f;
    localparam logic [7:0] IDX_EVT_STATUS  = 8'h30;
    localparam logic [7:0] IDX_EVT_MASK    = 8'h31;
    localparam int         ADDR_W          = 12;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         BIT_ONE         = 7;
    localparam int         BIT_ZERO        = 6;
    localparam int         BIT_GIE         = 7;
    localparam int         SENSE_ONE_LSB   = 2;
    localparam int         SENSE_ZERO_LSB  = 0;
    localparam int         EVT_W           = 3;
    localparam int         EVT_SET_ZERO    = 0;
    localparam int         EVT_SET_ONE     = 1;
    localparam int         EVT_VECTOR      = 2;
    localparam logic [7:0] RESET_BYTE      = 8'h00;

    // ************************************************************
    // Sense codes, vectors and response timing
    // ************************************************************
    localparam logic [1:0]  SENSE_LOW      = 2'h0;
    localparam logic [1:0]  SENSE_FALL     = 2'h2;
    localparam logic [1:0]  SENSE_RISE     = 2'h3;
    localparam logic [11:0] VEC_ZERO       = 12'h001;
    localparam logic [11:0] VEC_ONE        = 12'h002;
    localparam int          RESPONSE_CYCLES = 4;
    localparam logic [2:0]  RESP_LAST      = 3'(RESPONSE_CYCLES - 1);

    typedef enum logic [0:0] {
        PH_IDLE,
        PH_WAIT
    } phase_t;

endpackage

// ==== inc/irq_sense_if.sv ====
// Synchronised pin levels and edges passed from the sampler to the controller
`timescale 1ns/10ps
`default_nettype none
interface irq_sense_if;
    logic [1:0] level;
    logic [1:0] rise;
    logic [1:0] fall;

    modport sampler (output level, rise, fall);
    modport user    (input  level, rise, fall);
endinterface
`default_nettype wire

// ==== logic/ext_irq_and_pending_logic.sv ====
// External interrupt pins, pending flags, priority and vectoring with APB registers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_and_pending_logic
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Processor core
    input  wire logic              core_busy,
    input  wire logic              core_return,
    output logic                   vec_valid,
    output logic [11:0]            vec_addr,
    // External request pins
    input  wire logic              ext_pin_zero,
    input  wire logic              ext_pin_one,
    // System interrupt
    output logic                   irq
);

    typedef struct packed {
        logic             gie;
        logic [1:0]       en;
        logic [1:0]       flag;
        logic [3:0]       sense;
        logic [EVT_W-1:0] evt_sts;
        logic [EVT_W-1:0] evt_msk;
        phase_t           phase;
        logic [2:0]       cnt;
        logic             vec_valid;
        logic [11:0]      vec_addr;
        logic [31:0]      prdata;
        logic             ready;
        logic             slverr;
        logic             irq;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    irq_sense_if sense_bus ();

    // ************************************************************
    // Pin sampling
    // ************************************************************
    irq_pin_sampler u_sampler (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .pin_in  ({ext_pin_one, ext_pin_zero}),
        .sense   (sense_bus)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr == {2'h0, idx, 2'h0});
    endfunction

    function automatic logic [1:0] sense_of(input logic [3:0] field, input int pin);
        sense_of = (pin == 0) ? field[SENSE_ZERO_LSB +: 2] : field[SENSE_ONE_LSB +: 2];
    endfunction

    function automatic logic [7:0] read_byte(input ctrl_state_t st, input logic [ADDR_W-1:0] a);
        read_byte = RESET_BYTE;
        if (hit(a, IDX_EXT_FLAGS)) begin
            read_byte[BIT_ONE:BIT_ZERO] = st.flag;
        end else if (hit(a, IDX_EXT_MASK)) begin
            read_byte[BIT_ONE:BIT_ZERO] = st.en;
        end else if (hit(a, IDX_MCU_CTRL)) begin
            read_byte[3:0] = st.sense;
        end else if (hit(a, IDX_STATUS_REG)) begin
            read_byte[BIT_GIE] = st.gie;
        end else if (hit(a, IDX_EVT_STATUS)) begin
            read_byte[EVT_W-1:0] = st.evt_sts;
        end else if (hit(a, IDX_EVT_MASK)) begin
            read_byte[EVT_W-1:0] = st.evt_msk;
        end
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, IDX_EXT_FLAGS) | hit(a, IDX_EXT_MASK) | hit(a, IDX_MCU_CTRL)
               | hit(a, IDX_STATUS_REG) | hit(a, IDX_EVT_STATUS) | hit(a, IDX_EVT_MASK);
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    logic [1:0]       level_req;
    logic [1:0]       edge_set;
    logic [1:0]       wr_clr;
    logic [1:0]       vec_clr;
    logic [1:0]       req;
    logic             setup;
    logic             done;
    logic             wr;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [1:0]       sn;

    always_comb begin
        next_s    = s;
        level_req = '0;
        edge_set  = '0;
        wr_clr    = '0;
        vec_clr   = '0;
        req       = '0;
        evt_set   = '0;
        evt_clr   = '0;
        sn        = '0;
        setup     = psel & ~penable;
        done      = psel & penable & s.ready;
        wr        = done & pwrite & ~s.slverr;

        // Sense decode per pin
        for (int i = 0; i < 2; i++) begin
            sn = sense_of(s.sense, i);
            level_req[i] = (sn == SENSE_LOW) & ~sense_bus.level[i];
            edge_set[i]  = ((sn == SENSE_RISE) & sense_bus.rise[i])
                         | ((sn == SENSE_FALL) & sense_bus.fall[i]);
        end

        // Requests: flag or live low level, gated by own enable
        req = s.en & (s.flag | level_req);

        if (clk_en) begin
            next_s.vec_valid = 1'b0;

            // Global enable from return
            if (core_return) begin
                next_s.gie = 1'b1;
            end

            // Response sequencing
            case (s.phase)
                PH_IDLE: begin
                    if (s.gie && (req != 2'h0)) begin
                        next_s.phase = PH_WAIT;
                        next_s.cnt   = 3'h1;
                    end
                end
                PH_WAIT: begin
                    if (!s.gie || (req == 2'h0)) begin
                        next_s.phase = PH_IDLE;
                        next_s.cnt   = 3'h0;
                    end else if (s.cnt < RESP_LAST) begin
                        next_s.cnt = s.cnt + 3'h1;
                    end else if (!core_busy) begin
                        next_s.phase     = PH_IDLE;
                        next_s.cnt       = 3'h0;
                        next_s.vec_valid = 1'b1;
                        next_s.gie       = 1'b0;
                        evt_set[EVT_VECTOR] = 1'b1;
                        if (req[0]) begin
                            next_s.vec_addr = VEC_ZERO;
                            vec_clr[0]      = 1'b1;
                        end else begin
                            next_s.vec_addr = VEC_ONE;
                            vec_clr[1]      = 1'b1;
                        end
                    end
                end
                default: begin
                    next_s.phase = PH_IDLE;
                    next_s.cnt   = 3'h0;
                end
            endcase

            // APB slave: answer one cycle after setup
            next_s.ready = setup;
            if (setup) begin
                next_s.prdata  = {24'h0, read_byte(s, paddr)};
                next_s.slverr  = ~mapped(paddr);
            end
            if (wr && hit(paddr, IDX_EXT_FLAGS)) begin
                wr_clr = pwdata[BIT_ONE:BIT_ZERO];
            end
            if (wr && hit(paddr, IDX_EXT_MASK)) begin
                next_s.en = pwdata[BIT_ONE:BIT_ZERO];
            end
            if (wr && hit(paddr, IDX_MCU_CTRL)) begin
                next_s.sense = pwdata[3:0];
            end
            if (wr && hit(paddr, IDX_STATUS_REG) && !next_s.vec_valid) begin
                next_s.gie = pwdata[BIT_GIE];
            end
            if (wr && hit(paddr, IDX_EVT_MASK)) begin
                next_s.evt_msk = pwdata[EVT_W-1:0];
            end
            if (done && !pwrite && hit(paddr, IDX_EVT_STATUS)) begin
                evt_clr = s.prdata[EVT_W-1:0];
            end

            // Pending flags: set wins over clear, level mode holds zero
            for (int i = 0; i < 2; i++) begin
                if (sense_of(s.sense, i) == SENSE_LOW) begin
                    next_s.flag[i] = 1'b0;
                end else if (edge_set[i]) begin
                    next_s.flag[i] = 1'b1;
                end else if (wr_clr[i] || vec_clr[i]) begin
                    next_s.flag[i] = 1'b0;
                end
            end
            evt_set[EVT_SET_ZERO] = edge_set[0] & ~s.flag[0];
            evt_set[EVT_SET_ONE]  = edge_set[1] & ~s.flag[1];

            // Sticky event status, read to clear, set wins
            next_s.evt_sts = (s.evt_sts & ~evt_clr) | evt_set;
            next_s.irq     = |(next_s.evt_sts & s.evt_msk);
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata    = s.prdata;
    assign pready    = s.ready;
    assign pslverr   = s.slverr;
    assign vec_valid = s.vec_valid;
    assign vec_addr  = s.vec_addr;
    assign irq       = s.irq;

endmodule
`default_nettype wire

// ==== logic/irq_pin_sampler.sv ====
// Two-stage synchroniser and edge detector for the external request pins
`timescale 1ns/10ps
`default_nettype none
module irq_pin_sampler
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     clk_en,
    // Pads
    input  wire logic [1:0] pin_in,
    // To controller
    irq_sense_if.sampler  sense
);

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [1:0] rise;
        logic [1:0] fall;
        logic [1:0] warm;
    } sampler_state_t;

    sampler_state_t s;
    sampler_state_t next_s;

    // ************************************************************
    // Edge detection
    // ************************************************************
    always_comb begin
        next_s = s;
        if (clk_en) begin
            next_s.sync1 = pin_in;
            next_s.sync2 = s.sync1;
            next_s.prev  = s.sync2;
            next_s.warm  = (s.warm == 2'h3) ? s.warm : s.warm + 2'h1;
            // No edges until the chain holds real pin levels after reset
            next_s.rise  = (s.warm == 2'h3) ? (s.sync2 & ~s.prev) : 2'h0;
            next_s.fall  = (s.warm == 2'h3) ? (~s.sync2 & s.prev) : 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sense.level = s.sync2;
    assign sense.rise  = s.rise;
    assign sense.fall  = s.fall;

endmodule
`default_nettype wire

// ==== tb/ext_irq_properties.sv ====
// Port checker for the external interrupt and pending logic
`timescale 1ns/10ps
`default_nettype none
module ext_irq_checker
    import irq_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    // Core and interrupt
    input  wire logic              clk_en,
    input  wire logic              core_busy,
    input  wire logic              vec_valid,
    input  wire logic [11:0]       vec_addr,
    input  wire logic              irq
);
    localparam logic [ADDR_W-1:0] A_FLAGS = ADDR_W'({IDX_EXT_FLAGS, 2'b00});
    localparam logic [ADDR_W-1:0] A_MASK  = ADDR_W'({IDX_EXT_MASK, 2'b00});

    // ************************************************************
    // Sequences
    // ************************************************************
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read_done;
        pready && !pwrite;
    endsequence

    // ************************************************************
    // Properties
    // ************************************************************
    a_pready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready) else $error("pready missing after setup");
    a_pready_in_access: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> psel && penable) else $error("pready outside access");
    a_unmapped_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_done ##0 pslverr |-> prdata == 32'h0) else $error("error read not zero");
    a_upper_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_done |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    a_reserved_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_done ##0 (paddr == A_FLAGS || paddr == A_MASK) |-> prdata[5:0] == 6'h0)
        else $error("reserved bits not zero");
    a_vec_addr_legal: assert property (@(posedge pclk) disable iff (!presetn)
        vec_valid |-> vec_addr == VEC_ZERO || vec_addr == VEC_ONE) else $error("bad vector");
    a_vec_gap_four: assert property (@(posedge pclk) disable iff (!presetn)
        vec_valid |=> !vec_valid [*3]) else $error("vectors too close");
    a_busy_holds_vec: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && core_busy |=> !vec_valid) else $error("vector while core busy");
    a_reset_quiet: assert property (@(posedge pclk)
        !presetn |-> !vec_valid && !irq && !pready) else $error("outputs active in reset");
endmodule
`default_nettype wire

bind ext_irq_and_pending_logic ext_irq_checker i_ext_irq_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_en(clk_en), .core_busy(core_busy),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .irq(irq));

// ==== tb/irq_pin_model.sv ====
// Board-side driver of the two external request pins
`timescale 1ns/10ps
`default_nettype none
module irq_pin_model (
    // Clock
    input  wire logic pclk,
    // Pads
    output logic      pin_zero,
    output logic      pin_one
);
    initial begin
        pin_zero = 1'b0;
        pin_one  = 1'b1;
    end

    // ************************************************************
    // Pin levels change just after a rising edge
    // ************************************************************
    task automatic drive(input logic [1:0] v);
        @(posedge pclk);
        pin_zero <= v[0];
        pin_one  <= v[1];
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_ext_irq_and_pending_logic.sv ====
// Register-level testbench of the external interrupt and pending logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin miscompares++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_ext_irq_and_pending_logic;
    import irq_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              core_return = 1'b0;
    logic              clk_en = 1'b1;
    logic              core_busy = 1'b0;
    logic              vec_valid;
    logic [11:0]       vec_addr;
    logic              pin_zero;
    logic              pin_one;
    logic              irq;
    logic              hit;
    logic [11:0]       va;
    int                miscompares = 0;
    int                compares = 0;

    always #25 pclk = ~pclk;

    irq_pin_model i_irq_pin_model (.pclk(pclk), .pin_zero(pin_zero), .pin_one(pin_one));
    ext_irq_and_pending_logic i_ext_irq_and_pending_logic (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_busy(core_busy), .core_return(core_return),
        .vec_valid(vec_valid), .vec_addr(vec_addr), .ext_pin_zero(pin_zero),
        .ext_pin_one(pin_one), .irq(irq));

    // ************************************************************
    // Bus and core tasks
    // ************************************************************
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= ADDR_W'({idx, 2'b00}); pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) miscompares++;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(idx, 1'b1, d, r, e);
    endtask
    task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(idx, 1'b0, 8'h0, r, e);
        `CHK(n, exp, r)
    endtask
    task automatic wait_vec(input int n);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(posedge pclk);
            if (vec_valid === 1'b1) begin hit = 1'b1; va = vec_addr; end
        end
    endtask
    task automatic ret_pulse();
        @(posedge pclk); core_return <= 1'b1;
        @(posedge pclk); core_return <= 1'b0;
    endtask
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        stop_test();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        logic [7:0] r;
        logic e;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd("flags", IDX_EXT_FLAGS, 8'h00);
        rd("mask", IDX_EXT_MASK, 8'h00);
        rd("ctrl", IDX_MCU_CTRL, 8'h00);
        rd("status", IDX_STATUS_REG, 8'h00);
        apb(8'h00, 1'b0, 8'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
        wr(IDX_EXT_MASK, 8'hff);
        rd("mask rsvd", IDX_EXT_MASK, 8'hc0);
        wr(IDX_EXT_MASK, 8'h00);
        $display("test reset_regs done");
        wr(IDX_MCU_CTRL, {4'h0, SENSE_FALL, SENSE_RISE});
        i_irq_pin_model.drive(2'b01);
        repeat (5) @(posedge pclk);
        rd("edge flags", IDX_EXT_FLAGS, 8'hc0);
        wr(IDX_EXT_FLAGS, 8'h00);
        rd("write zero", IDX_EXT_FLAGS, 8'hc0);
        wr(IDX_EXT_FLAGS, 8'h80);
        rd("write one", IDX_EXT_FLAGS, 8'h40);
        wr(IDX_EXT_FLAGS, 8'h40);
        repeat (5) @(posedge pclk);
        rd("static", IDX_EXT_FLAGS, 8'h00);
        $display("test edge_flags done");
        i_irq_pin_model.drive(2'b10);
        i_irq_pin_model.drive(2'b01);
        repeat (5) @(posedge pclk);
        rd("pending", IDX_EXT_FLAGS, 8'hc0);
        wr(IDX_EXT_MASK, 8'hc0);
        wr(IDX_STATUS_REG, 8'h80);
        wait_vec(30);
        `CHK("first vec", VEC_ZERO, va)
        rd("hw clear", IDX_EXT_FLAGS, 8'h80);
        rd("gie off", IDX_STATUS_REG, 8'h00);
        ret_pulse();
        wait_vec(30);
        `CHK("second vec", VEC_ONE, va)
        rd("all served", IDX_EXT_FLAGS, 8'h00);
        $display("test priority done");
        wr(IDX_MCU_CTRL, 8'h00);
        rd("level flag", IDX_EXT_FLAGS, 8'h00);
        wr(IDX_STATUS_REG, 8'h80);
        wait_vec(30);
        `CHK("level vec", VEC_ONE, va)
        i_irq_pin_model.drive(2'b11);
        ret_pulse();
        wait_vec(20);
        `CHK("level gone", 1'b0, hit)
        wr(IDX_EXT_MASK, 8'h00);
        $display("test level done");
        rd("evt clear", IDX_EVT_STATUS, 8'h07);
        wr(IDX_MCU_CTRL, {4'h0, SENSE_LOW, SENSE_FALL});
        i_irq_pin_model.drive(2'b10);
        repeat (5) @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        wr(IDX_EVT_MASK, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        rd("evt status", IDX_EVT_STATUS, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test events done");
        @(posedge pclk);
        core_busy <= 1'b1;
        wr(IDX_EXT_MASK, 8'h40);
        wait_vec(20);
        `CHK("busy holds", 1'b0, hit)
        core_busy <= 1'b0;
        wait_vec(5);
        `CHK("busy vec", VEC_ZERO, va)
        $display("test busy done");
        @(posedge pclk);
        clk_en <= 1'b0;
        i_irq_pin_model.drive(2'b11);
        i_irq_pin_model.drive(2'b10);
        repeat (4) @(posedge pclk);
        clk_en <= 1'b1;
        repeat (5) @(posedge pclk);
        rd("frozen", IDX_EXT_FLAGS, 8'h00);
        $display("test freeze done");
        wr(IDX_EXT_MASK, 8'h80);
        wr(IDX_MCU_CTRL, 8'hff);
        wr(IDX_STATUS_REG, 8'h80);
        i_irq_pin_model.drive(2'b11);
        repeat (5) @(posedge pclk);
        rd("pre reset", IDX_EXT_FLAGS, 8'h40);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd("rst flags", IDX_EXT_FLAGS, 8'h00);
        rd("rst mask", IDX_EXT_MASK, 8'h00);
        rd("rst ctrl", IDX_MCU_CTRL, 8'h00);
        rd("rst status", IDX_STATUS_REG, 8'h00);
        $display("test reset done");
        stop_test();
    end
endmodule
`default_nettype wire
